// *** rdtf_remote_temp.sv ***
// Added by the designer: the APB slave port.
`include "rdtf_defines.svh"

module rdtf_remote_temp
    import rdtf_pkg::*;
#(
    parameter int AVG_N = `RDTF_AVG_COUNT
)
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Converter and bias control
    output logic             adc_start,
    input  wire logic        adc_valid,
    input  wire logic [9:0]  adc_data,
    output rdtf_bias_t       bias_sel,
    output logic             chan_sel,
    // Diode fault pins
    input  wire logic [1:0]  diode_fault
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register bus decode

    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        return a == {2'b00, idx, 2'b00};
    endfunction : hit

    function automatic rdtf_bias_t bias_of(input rdtf_seq_t s);
        case (s)
            SEQ_MULT1: return BIAS_N1;
            SEQ_MULT2: return BIAS_N2;
            default:   return BIAS_I;
        endcase
    endfunction : bias_of

    logic      [31:0] prdata_r;
    logic             pready_r;
    logic             pslverr_r;
    logic      [7:0]  ofs_r [2];
    logic      [7:0]  cfg_r;
    logic      [7:0]  vis_val_r [2];
    logic      [1:0]  vis_frac_r [2];
    logic      [7:0]  shd_val_r [2];
    logic      [1:0]  shd_frac_r [2];
    logic             frozen_r;
    logic             frozen_nxt;
    logic      [1:0]  seen_r;
    logic      [1:0]  seen_nxt;

    wire setup   = psel & ~penable;
    wire done    = psel & penable & pready_r;
    wire wr_done = done & pwrite & pstrb[0];
    wire rd_done = done & ~pwrite;
    wire h_v0    = hit(paddr, `RDTF_IDX_VAL1);
    wire h_v1    = hit(paddr, `RDTF_IDX_VAL2);
    wire h_o0    = hit(paddr, `RDTF_IDX_OFS1);
    wire h_o1    = hit(paddr, `RDTF_IDX_OFS2);
    wire h_fr    = hit(paddr, `RDTF_IDX_FRAC);
    wire h_cf    = hit(paddr, `RDTF_IDX_CFG5);
    wire mapped  = h_v0 | h_v1 | h_o0 | h_o1 | h_fr | h_cf;
    wire compat  = cfg_r[`RDTF_COMPAT_BIT];

    logic [7:0] frac_byte;
    logic [7:0] rd_byte;

    // Both channels' quarters in one byte
    assign frac_byte = {vis_frac_r[1], 2'b00, vis_frac_r[0], 2'b00};
    assign rd_byte   = h_v0 ? vis_val_r[0] :
                       h_v1 ? vis_val_r[1] :
                       h_o0 ? ofs_r[0] :
                       h_o1 ? ofs_r[1] :
                       h_fr ? frac_byte :
                       h_cf ? cfg_r : 8'h00;

    // Data captured at setup so the access phase never waits
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r  <= 32'h0000_0000;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            if (setup)
                prdata_r <= (mapped & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ofs_r[0] <= `RDTF_OFS_RST;
            ofs_r[1] <= `RDTF_OFS_RST;
            cfg_r    <= `RDTF_CFG5_RST;
        end
        else if (wr_done)
        begin
            if (h_o0)
                ofs_r[0] <= pwdata[7:0];
            if (h_o1)
                ofs_r[1] <= pwdata[7:0];
            if (h_cf)
                cfg_r <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Freeze of the visible result registers

    // Freeze starts at setup so the returned fraction matches the frozen bytes
    wire fr_rd = setup & ~pwrite & h_fr;
    wire hold  = frozen_r | fr_rd;

    assign seen_nxt   = fr_rd ? 2'b00 : (seen_r | {rd_done & h_v1, rd_done & h_v0});
    assign frozen_nxt = fr_rd | (frozen_r & ~(&seen_nxt));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frozen_r <= 1'b0;
            seen_r   <= 2'b00;
        end
        else
        begin
            frozen_r <= frozen_nxt;
            seen_r   <= seen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Diode fault synchronisers

    logic [1:0] flt_m_r;
    logic [1:0] flt_s_r;

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_flt
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    flt_m_r[g] <= 1'b0;
                    flt_s_r[g] <= 1'b0;
                end
                else
                begin
                    flt_m_r[g] <= diode_fault[g];
                    flt_s_r[g] <= flt_m_r[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Bias sequencer and averaging

    rdtf_seq_t          st_r;
    rdtf_seq_t          st_nxt;
    rdtf_bias_t         bias_r;
    logic               ch_r;
    logic               start_r;
    logic               wait_r;
    logic               first_r;
    logic [4:0]         cnt_r;
    logic [9:0]         base1_r;
    logic [9:0]         mult1_r;
    logic [9:0]         base2_r;
    logic signed [16:0] acc_r;
    logic signed [16:0] acc_nxt;
    logic signed [10:0] dv1;
    logic signed [10:0] dv2;
    logic signed [12:0] tcyc;
    rdtf_res_t          fmt;

    wire adv  = adc_valid & wait_r;
    wire cyc  = adv & (st_r == SEQ_MULT2);
    wire last = cyc & (cnt_r == 5'(AVG_N - 1));

    // Base, N1, base, N2 in order
    always_comb
    begin
        st_nxt = st_r;
        if (adv)
        begin
            case (st_r)
                SEQ_BASE1: st_nxt = SEQ_MULT1;
                SEQ_MULT1: st_nxt = SEQ_BASE2;
                SEQ_BASE2: st_nxt = SEQ_MULT2;
                SEQ_MULT2: st_nxt = SEQ_BASE1;
                default:   st_nxt = SEQ_BASE1;
            endcase
        end
    end

    assign dv1     = $signed({1'b0, mult1_r}) - $signed({1'b0, base1_r});
    assign dv2     = $signed({1'b0, adc_data}) - $signed({1'b0, base2_r});
    assign tcyc    = ($signed({{2{dv1[10]}}, dv1}) <<< 1) - $signed({{2{dv2[10]}}, dv2});
    assign acc_nxt = acc_r + $signed({{4{tcyc[12]}}, tcyc});

    // Offset applied to the averaged value
    rdtf_format u_fmt (
        .temp_q (acc_nxt[`RDTF_AVG_SHIFT +: 13]),
        .offset (ofs_r[ch_r]),
        .compat (compat),
        .fault  (flt_s_r[ch_r]),
        .res    (fmt)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r    <= SEQ_BASE1;
            bias_r  <= BIAS_I;
            first_r <= 1'b1;
            start_r <= 1'b0;
            wait_r  <= 1'b0;
        end
        else
        begin
            st_r    <= st_nxt;
            bias_r  <= bias_of(st_nxt);
            first_r <= 1'b0;
            start_r <= first_r | adv;
            wait_r  <= start_r | (wait_r & ~adv);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            base1_r <= 10'h000;
            mult1_r <= 10'h000;
            base2_r <= 10'h000;
        end
        else if (adv)
        begin
            if (st_r == SEQ_BASE1)
                base1_r <= adc_data;
            if (st_r == SEQ_MULT1)
                mult1_r <= adc_data;
            if (st_r == SEQ_BASE2)
                base2_r <= adc_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r <= 17'sh0_0000;
            cnt_r <= 5'h00;
            ch_r  <= 1'b0;
        end
        else if (cyc)
        begin
            acc_r <= last ? 17'sh0_0000 : acc_nxt;
            cnt_r <= last ? 5'h00 : cnt_r + 5'h01;
            ch_r  <= ch_r ^ last;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                shd_val_r[i]  <= `RDTF_VAL_RST;
                shd_frac_r[i] <= 2'b00;
                vis_val_r[i]  <= `RDTF_VAL_RST;
                vis_frac_r[i] <= 2'b00;
            end
        end
        else
        begin
            if (last)
            begin
                shd_val_r[ch_r]  <= fmt.val;
                shd_frac_r[ch_r] <= fmt.frac;
            end
            if (!hold)
            begin
                vis_val_r  <= shd_val_r;
                vis_frac_r <= shd_frac_r;
            end
        end
    end

    assign adc_start = start_r;
    assign bias_sel  = bias_r;
    assign chan_sel  = ch_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Samples since last result, kept apart from the cycle counter
    logic [7:0] smp_cnt_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            smp_cnt_r <= 8'h00;
        else if (last)
            smp_cnt_r <= 8'h00;
        else if (adv)
            smp_cnt_r <= smp_cnt_r + 8'h01;
    end

    sequence s_step1;
        st_r == SEQ_BASE1 && adv;
    endsequence

    sequence s_step2;
        st_r == SEQ_BASE2 && adv;
    endsequence

    bias_n1_a:   assert property (s_step1 |=> bias_r == BIAS_N1 && st_r == SEQ_MULT1)
        else $error("N1 bias not after first base step");
    bias_n2_a:   assert property (s_step2 |=> bias_r == BIAS_N2 && st_r == SEQ_MULT2)
        else $error("N2 bias not after second base step");
    avg_count_a: assert property (last |-> smp_cnt_r == 8'(4 * AVG_N - 1))
        else $error("Result published after wrong sample count");
    avg_range_a: assert property (cnt_r < 5'(AVG_N))
        else $error("Averaging counter out of range");
    fault_twos_a: assert property (last && compat && flt_s_r[ch_r] |=>
        shd_val_r[$past(ch_r)] == `RDTF_FAULT_TWOS)
        else $error("Wrong fault code in twos complement mode");
    ext_zero_a:  assert property (u_fmt.sum == 14'sh0000 && !compat &&
        !flt_s_r[ch_r] |-> fmt.val == 8'h40 && fmt.frac == 2'b00)
        else $error("Zero degrees not 0x40 in extended mode");
    ofs_write_a: assert property (wr_done && h_o0 |=>
        ofs_r[0] == $past(pwdata[7:0]))
        else $error("Offset write not stored");
    frz_hold_a:  assert property (frozen_r |=> $stable(vis_val_r[0]) &&
        $stable(vis_frac_r[0]) || !$past(frozen_r))
        else $error("Value changed while frozen");
    frz_end_a:   assert property (frozen_r && !fr_rd && &seen_nxt |=> !frozen_r)
        else $error("Freeze not released after both reads");
    apb_wait_a:  assert property (setup |=> pready ##1 !pready)
        else $error("Access phase not exactly one cycle");

endmodule : rdtf_remote_temp

// *** rdtf_defines.svh ***
`ifndef RDTF_DEFINES_SVH
`define RDTF_DEFINES_SVH

// Register indices; byte address is four times the index
`define RDTF_IDX_VAL1      8'h25
`define RDTF_IDX_VAL2      8'h27
`define RDTF_IDX_OFS1      8'h70
`define RDTF_IDX_OFS2      8'h72
`define RDTF_IDX_FRAC      8'h77
`define RDTF_IDX_CFG5      8'h7c

// Field positions
`define RDTF_COMPAT_BIT    1
`define RDTF_FRAC1_LSB     2
`define RDTF_FRAC2_LSB     6

// Reset values
`define RDTF_OFS_RST       8'h00
`define RDTF_CFG5_RST      8'h00
`define RDTF_VAL_RST       8'h00

// Averaging
`define RDTF_AVG_COUNT     16
`define RDTF_AVG_SHIFT     4

// Codes and limits in quarter degrees
`define RDTF_FAULT_TWOS    8'h80
`define RDTF_FAULT_EXT     8'h00
`define RDTF_QMIN          14'sh3f00
`define RDTF_QMAX_TWOS     14'sh01ff
`define RDTF_QMAX_EXT      14'sh02ff
`define RDTF_EXT_BIAS      14'sh0100

`endif

// *** rdtf_pkg.sv ***
package rdtf_pkg;

    typedef enum logic [1:0] {BIAS_I, BIAS_N1, BIAS_N2} rdtf_bias_t;

    typedef enum logic [1:0] {SEQ_BASE1, SEQ_MULT1, SEQ_BASE2, SEQ_MULT2} rdtf_seq_t;

    typedef struct packed {
        logic [7:0] val;
        logic [1:0] frac;
    } rdtf_res_t;

endpackage : rdtf_pkg

// *** rdtf_format.sv ***
`include "rdtf_defines.svh"

module rdtf_format
    import rdtf_pkg::*;
(
    // Averaged result and settings
    input  wire logic signed [12:0] temp_q,
    input  wire logic        [7:0]  offset,
    input  wire logic               compat,
    input  wire logic               fault,
    // Formatted result
    output rdtf_res_t               res
);

    logic signed [13:0] sum;
    logic signed [13:0] lim_hi;
    logic signed [13:0] clp;
    logic signed [13:0] ext;
    logic        [9:0]  code;

    // Offset added, half degree per count
    assign sum    = {temp_q[12], temp_q} + {{5{offset[7]}}, offset, 1'b0};
    assign lim_hi = compat ? `RDTF_QMAX_TWOS : `RDTF_QMAX_EXT;
    assign clp    = (sum < `RDTF_QMIN) ? `RDTF_QMIN : ((sum > lim_hi) ? lim_hi : sum);
    assign ext    = clp + `RDTF_EXT_BIAS;
    // Twos complement keeps low ten bits
    assign code   = compat ? clp[9:0] : ext[9:0];

    assign res.val  = fault ? (compat ? `RDTF_FAULT_TWOS : `RDTF_FAULT_EXT) : code[9:2];
    assign res.frac = fault ? 2'b00 : code[1:0];

endmodule : rdtf_format

// *** rdtf_diode_model.sv ***
module rdtf_diode_model
    import rdtf_pkg::*;
(
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Converter side
    input  wire logic               adc_start,
    input  wire rdtf_bias_t         bias_sel,
    input  wire logic               chan_sel,
    output logic                    adc_valid,
    output logic [9:0]              adc_data,
    // Scenario controls
    input  wire logic signed [11:0] tq1,
    input  wire logic signed [11:0] tq2,
    input  wire logic               slow,
    output logic                    seq_bad
);
    timeunit 1ns;
    timeprecision 1ps;

    logic       [1:0]  wait_r;
    logic              busy_r;
    logic       [9:0]  code_r;
    logic       [6:0]  cnt_r;
    logic signed [11:0] tq;
    rdtf_bias_t        exp_bias;
    logic       [9:0]  code;

    // Bias order I, N1, I, N2
    assign exp_bias = cnt_r[0] ? (cnt_r[1] ? BIAS_N2 : BIAS_N1) : BIAS_I;
    assign tq       = chan_sel ? tq2 : tq1;
    // Codes chosen so 2*(N1-I)-(N2-I) equals tq
    assign code     = (bias_sel == BIAS_I) ? 10'h12c :
                      (bias_sel == BIAS_N1) ? 10'h1f4 : 10'(12'sd700 - tq);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            adc_valid <= 1'b0;
            adc_data  <= 10'h2aa;
            busy_r    <= 1'b0;
            wait_r    <= 2'h0;
            code_r    <= 10'h000;
            cnt_r     <= 7'h00;
            seq_bad   <= 1'b0;
        end
        else
        begin
            adc_valid <= 1'b0;
            // Stale data must not look valid after the strobe
            if (adc_valid)
                adc_data <= ~adc_data;
            if (adc_start)
            begin
                if (bias_sel !== exp_bias || chan_sel !== cnt_r[6])
                    seq_bad <= 1'b1;
                cnt_r  <= cnt_r + 7'h01;
                busy_r <= 1'b1;
                wait_r <= slow ? 2'h3 : 2'h0;
                code_r <= code;
            end
            else if (busy_r)
            begin
                if (wait_r == 2'h0)
                begin
                    adc_valid <= 1'b1;
                    adc_data  <= code_r;
                    busy_r    <= 1'b0;
                end
                else
                    wait_r <= wait_r - 2'h1;
            end
        end
    end
endmodule : rdtf_diode_model

// *** tb.sv ***
`include "rdtf_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rdtf_pkg::*;

    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic              adc_start, adc_valid, chan_sel, slow, seq_bad;
    logic       [11:0] paddr;
    logic       [31:0] pwdata, prdata, rdat;
    logic       [3:0]  pstrb;
    logic       [9:0]  adc_data;
    logic       [1:0]  diode_fault;
    logic signed [11:0] tq1, tq2;
    rdtf_bias_t        bias_sel;
    int                num_errors, compares;

    rdtf_remote_temp #(.AVG_N(16)) i_rdtf_remote_temp (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .adc_start(adc_start), .adc_valid(adc_valid), .adc_data(adc_data),
        .bias_sel(bias_sel), .chan_sel(chan_sel), .diode_fault(diode_fault));
    rdtf_diode_model i_rdtf_diode_model (.pclk(pclk), .presetn(presetn),
        .adc_start(adc_start), .bias_sel(bias_sel), .chan_sel(chan_sel),
        .adc_valid(adc_valid), .adc_data(adc_data), .tq1(tq1), .tq2(tq2),
        .slow(slow), .seq_bad(seq_bad));

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Setup cycle, then hold until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        chk({31'h0, pslverr}, {31'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00, 1'b0);
        chk(rdat, exp);
    endtask : rd

    task automatic wait_starts(input int n);
        repeat (n) @(posedge pclk iff adc_start === 1'b1);
    endtask : wait_starts

    // Quarter degrees to stored 10-bit code
    function automatic logic [9:0] expq(input int q, input logic [7:0] o, input logic c);
        int t;
        t = q + 2 * $signed(o);
        if (t < -256)
            t = -256;
        if (c && t > 511)
            t = 511;
        if (!c && t > 767)
            t = 767;
        if (!c)
            t = t + 256;
        return t[9:0];
    endfunction : expq

    task automatic run_case(input int q1, input int q2, input logic [7:0] o1,
                            input logic [7:0] o2, input logic c, input logic [1:0] f);
        logic [9:0] e1, e2;
        logic [7:0] fv, m;
        e1 = expq(q1, o1, c);
        e2 = expq(q2, o2, c);
        fv = c ? `RDTF_FAULT_TWOS : `RDTF_FAULT_EXT;
        m  = {f[1] ? 2'b00 : 2'b11, 2'b11, f[0] ? 2'b00 : 2'b11, 2'b11};
        apb(1'b1, `RDTF_IDX_OFS1, o1, 1'b0);
        apb(1'b1, `RDTF_IDX_OFS2, o2, 1'b0);
        apb(1'b1, `RDTF_IDX_CFG5, {6'h00, c, 1'b0}, 1'b0);
        tq1         <= 12'(q1);
        tq2         <= 12'(q2);
        diode_fault <= f;
        wait_starts(260);
        rd(`RDTF_IDX_OFS1, {24'h0, o1});
        rd(`RDTF_IDX_CFG5, {30'h0, c, 1'b0});
        apb(1'b0, `RDTF_IDX_FRAC, 8'h00, 1'b0);
        chk(rdat & {24'h0, m}, {24'h0, e2[1:0], 2'b00, e1[1:0], 2'b00} & m);
        rd(`RDTF_IDX_VAL1, {24'h0, f[0] ? fv : e1[9:2]});
        rd(`RDTF_IDX_VAL2, {24'h0, f[1] ? fv : e2[9:2]});
    endtask : run_case

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        #(60000 * 100);
        num_errors++;
        end_sim();
    end

    initial
    begin
        presetn     = 1'b0;
        {psel, penable, pwrite, slow} = 4'h0;
        paddr       = 12'h000;
        pwdata      = 32'h0;
        pstrb       = 4'h1;
        diode_fault = 2'b00;
        tq1         = 12'sd0;
        tq2         = 12'sd0;
        num_errors  = 0;
        compares    = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(`RDTF_IDX_OFS1, 32'h0);
        rd(`RDTF_IDX_OFS2, 32'h0);
        rd(`RDTF_IDX_CFG5, 32'h0);
        apb(1'b0, 8'h71, 8'h00, 1'b1);
        chk(rdat, 32'h0);
        // Write with byte lane 0 off leaves the offset alone
        pstrb <= 4'h0;
        apb(1'b1, `RDTF_IDX_OFS1, 8'h33, 1'b0);
        pstrb <= 4'h1;
        rd(`RDTF_IDX_OFS1, 32'h0);
        run_case(100, 41, 8'h00, 8'h00, 1'b0, 2'b00);
        apb(1'b1, `RDTF_IDX_VAL1, 8'h55, 1'b0);
        rd(`RDTF_IDX_VAL1, 32'h59);
        slow <= 1'b1;
        run_case(100, 41, 8'hfe, 8'h04, 1'b0, 2'b00);
        run_case(700, -300, 8'h7f, 8'h80, 1'b0, 2'b00);
        slow <= 1'b0;
        run_case(-41, 2, 8'h00, 8'h01, 1'b1, 2'b00);
        run_case(700, -300, 8'h00, 8'h00, 1'b1, 2'b00);
        run_case(100, 41, 8'h00, 8'h00, 1'b1, 2'b01);
        run_case(100, 41, 8'h00, 8'h00, 1'b0, 2'b10);
        run_case(100, 41, 8'h00, 8'h00, 1'b0, 2'b00);
        // Freeze must hold old values while newer results arrive
        apb(1'b0, `RDTF_IDX_FRAC, 8'h00, 1'b0);
        chk(rdat, 32'h40);
        tq1 <= 12'sd201;
        wait_starts(260);
        rd(`RDTF_IDX_VAL2, 32'h4a);
        rd(`RDTF_IDX_VAL1, 32'h59);
        rd(`RDTF_IDX_FRAC, 32'h44);
        rd(`RDTF_IDX_VAL1, 32'h72);
        rd(`RDTF_IDX_VAL2, 32'h4a);
        chk({31'h0, seq_bad}, 32'h0);
        end_sim();
    end
endmodule : tb
